// [design/umrc_pkg.sv]
/*
  Constants, register map and state types for the serial receive control
  block. Assumes a byte-wide register port and a single 200 MHz clock.
*/

package umrc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] REG_SERIAL_PORT_CONTROL = 8'h98;
  localparam logic [7:0] REG_DATA_BUFFER = 8'h99;
  localparam logic [7:0] REG_AUX_CONTROL = 8'hC0;
  localparam logic [7:0] REG_BAUD_RELOAD = 8'hC1;
  localparam logic [7:0] REG_GIVEN_ADDRESS = 8'hC2;
  localparam logic [7:0] REG_ADDRESS_MASK = 8'hC3;
  localparam logic [7:0] REG_IRQ_STATUS = 8'hC4;
  localparam logic [7:0] REG_IRQ_MASK = 8'hC5;

  // ==========================================================================
  // Field positions
  localparam int BIT_MODE_HIGH = 7;
  localparam int BIT_MODE_LOW = 6;
  localparam int BIT_FILTER_ENABLE = 5;
  localparam int BIT_RECEIVE_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam int BIT_DOUBLE_RATE = 7;
  localparam int BIT_FRAMING_SELECT = 6;
  localparam int EVT_RX_DONE = 0;
  localparam int EVT_TX_DONE = 1;
  localparam int EVT_FRAMING = 2;
  localparam int EVT_OVERRUN = 3;
  localparam int EVT_COUNT = 4;

  // ==========================================================================
  // Reset values and modes
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
  localparam logic [1:0] MODE_UART9_TIMER = 2'h3;

  // ==========================================================================
  // Timing: sixteen ticks per bit, sampled at the middle tick.
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [9:0] FIXED_DIV = 10'h002;

  typedef enum logic [1:0] {
    UMRC_RX_IDLE = 2'b00,
    UMRC_RX_START = 2'b01,
    UMRC_RX_DATA = 2'b10,
    UMRC_RX_STOP = 2'b11
  } umrc_rx_state_t;

  typedef enum logic [1:0] {
    UMRC_TX_IDLE = 2'b00,
    UMRC_TX_START = 2'b01,
    UMRC_TX_DATA = 2'b10,
    UMRC_TX_STOP = 2'b11
  } umrc_tx_state_t;

endpackage

// [design/umrc_pin_sync.sv]
/*
  Three-flop input synchroniser with agreement filter for the receive pin.
  Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module umrc_pin_sync
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ==========================================================================
  // Synchroniser chain
  // The line idles high, so reset to one to avoid a false start edge.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ==========================================================================
  // Agreement filter
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      level <= 1'b1;
    else if (stage2 == stage3)
      level <= stage3;
  end

endmodule // umrc_pin_sync

`default_nettype wire

// [design/umrc_top.sv]
/*
  Serial port receive control with multiprocessor address filtering,
  framing error detection and a minimal transmit path for modes 1 to 3.
  Assumes a byte register port with one-cycle strobes and read data the
  cycle after a read strobe; the serial line is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module umrc_top
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rxd_pin,
  output logic txd,
  output logic serial_irq
);

  logic [1:0] serial_mode;
  logic multiproc_filter_enable;
  logic receive_enable;
  logic transmit_ninth_bit;
  logic received_ninth_bit;
  logic transmit_done_flag;
  logic receive_done_flag;
  logic framing_error_flag;
  logic framing_access_select;
  logic double_rate;
  logic [7:0] baud_reload;
  logic [7:0] given_address;
  logic [7:0] address_mask;
  logic [7:0] rx_data;

  localparam int EVT_COUNT_W = umrc_pkg::EVT_COUNT;

  logic [EVT_COUNT_W-1:0] irq_status;
  logic [EVT_COUNT_W-1:0] irq_mask;

  logic rx_level;
  logic rx_level_prev;
  logic [9:0] div_cnt;
  logic tick;
  umrc_pkg::umrc_rx_state_t rx_state;
  logic [3:0] rx_tick;
  logic [3:0] rx_bits;
  logic [8:0] rx_shift;
  logic rx_frame_done;
  logic rx_stop_bit;
  umrc_pkg::umrc_tx_state_t tx_state;
  logic [3:0] tx_tick;
  logic [3:0] tx_bits;
  logic [8:0] tx_shift;
  logic tx_stop_pulse;

  logic wr_control;
  logic wr_data;
  logic wr_status;
  logic nine_bit_mode;
  logic uart_mode;
  logic [3:0] frame_bits;
  logic [9:0] div_period;
  logic frame_ninth;
  logic addr_match;
  logic frame_accept;
  logic rx_load;
  logic rx_overrun;
  logic framing_evt;
  logic [EVT_COUNT_W-1:0] evt_vec;

  // ==========================================================================
  // Helpers
  function automatic logic addr_hit(input logic [7:0] byte_in,
                                    input logic [7:0] addr,
                                    input logic [7:0] mask);
    logic [7:0] bcast;
    bcast = addr | mask;
    addr_hit = ((byte_in & mask) == (addr & mask)) ||
               ((byte_in & bcast) == bcast);
  endfunction

  umrc_pin_sync umrc_pin_sync_i
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(rxd_pin),
    .level(rx_level)
  );

  // ==========================================================================
  // Decode
  // mode decoding
  assign nine_bit_mode = serial_mode[1];
  assign uart_mode = (serial_mode != umrc_pkg::MODE_SHIFT);
  assign frame_bits = nine_bit_mode ? umrc_pkg::BITS_NINE
                                    : umrc_pkg::BITS_EIGHT;
  assign wr_control = reg_wr &&
                      (reg_addr == umrc_pkg::REG_SERIAL_PORT_CONTROL);
  assign wr_data = reg_wr && (reg_addr == umrc_pkg::REG_DATA_BUFFER);
  assign wr_status = reg_wr && (reg_addr == umrc_pkg::REG_IRQ_STATUS);

  // ==========================================================================
  // Baud tick, sixteen per bit
  // Fixed mode divides the clock directly; timer modes use the reload value.
  always_comb
  begin
    if (serial_mode == umrc_pkg::MODE_UART9_FIXED)
      div_period = umrc_pkg::FIXED_DIV;
    else
      div_period = 10'(9'h100 - {1'b0, baud_reload}) << 1;
    if (double_rate)
      div_period = div_period >> 1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      div_cnt <= 10'h000;
      tick <= 1'b0;
    end
    else if (div_cnt + 10'h001 >= div_period)
    begin
      div_cnt <= 10'h000;
      tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 10'h001;
      tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Receiver
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rx_level_prev <= 1'b1;
    else
      rx_level_prev <= rx_level;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_state <= umrc_pkg::UMRC_RX_IDLE;
      rx_tick <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 9'h000;
      rx_frame_done <= 1'b0;
      rx_stop_bit <= 1'b0;
    end
    else
    begin
      rx_frame_done <= 1'b0;
      if (!receive_enable || !uart_mode)
        rx_state <= umrc_pkg::UMRC_RX_IDLE;
      else
      begin
        case (rx_state)
          umrc_pkg::UMRC_RX_IDLE:
          begin
            if (rx_level_prev && !rx_level)
            begin
              rx_state <= umrc_pkg::UMRC_RX_START;
              rx_tick <= 4'h0;
            end
          end
          umrc_pkg::UMRC_RX_START:
          begin
            if (tick)
            begin
              rx_tick <= rx_tick + 4'h1;
              if (rx_tick == umrc_pkg::TICK_MID)
              begin
                rx_tick <= 4'h0;
                rx_bits <= 4'h0;
                // A glitch shorter than half a bit is not a start bit.
                if (rx_level)
                  rx_state <= umrc_pkg::UMRC_RX_IDLE;
                else
                  rx_state <= umrc_pkg::UMRC_RX_DATA;
              end
            end
          end
          umrc_pkg::UMRC_RX_DATA:
          begin
            if (tick)
            begin
              rx_tick <= rx_tick + 4'h1;
              if (rx_tick == umrc_pkg::TICK_LAST)
              begin
                // shift in eight or nine bits
                rx_shift <= {rx_level, rx_shift[8:1]};
                rx_bits <= rx_bits + 4'h1;
                if (rx_bits + 4'h1 == frame_bits)
                  rx_state <= umrc_pkg::UMRC_RX_STOP;
              end
            end
          end
          umrc_pkg::UMRC_RX_STOP:
          begin
            if (tick)
            begin
              rx_tick <= rx_tick + 4'h1;
              // stop bit sampled at its middle
              if (rx_tick == umrc_pkg::TICK_LAST)
              begin
                rx_stop_bit <= rx_level;
                rx_frame_done <= 1'b1;
                if (!nine_bit_mode)
                  rx_shift <= {1'b0, rx_shift[8:1]};
                rx_state <= umrc_pkg::UMRC_RX_IDLE;
              end
            end
          end
          default:
            rx_state <= umrc_pkg::UMRC_RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Frame acceptance
  always_comb
  begin
    // ninth bit, or stop bit in mode 1
    frame_ninth = nine_bit_mode ? rx_shift[8] : rx_stop_bit;
    addr_match = addr_hit(rx_shift[7:0], given_address, address_mask);
    if (!multiproc_filter_enable)
      frame_accept = 1'b1;
    // valid stop needed in mode 1
    else if (!nine_bit_mode)
      frame_accept = rx_stop_bit && addr_match;
    else
      frame_accept = rx_shift[8] && addr_match;
    rx_load = rx_frame_done && frame_accept && !receive_done_flag;
    rx_overrun = rx_frame_done && frame_accept && receive_done_flag;
    framing_evt = rx_frame_done && !rx_stop_bit;
  end

  // ==========================================================================
  // Transmitter
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx_state <= umrc_pkg::UMRC_TX_IDLE;
      tx_tick <= 4'h0;
      tx_bits <= 4'h0;
      tx_shift <= 9'h000;
      txd <= 1'b1;
      tx_stop_pulse <= 1'b0;
    end
    else
    begin
      tx_stop_pulse <= 1'b0;
      case (tx_state)
        umrc_pkg::UMRC_TX_IDLE:
        begin
          txd <= 1'b1;
          if (wr_data && uart_mode)
          begin
            tx_shift <= {transmit_ninth_bit, reg_wdata};
            tx_tick <= 4'h0;
            tx_bits <= 4'h0;
            txd <= 1'b0;
            tx_state <= umrc_pkg::UMRC_TX_START;
          end
        end
        umrc_pkg::UMRC_TX_START,
        umrc_pkg::UMRC_TX_DATA:
        begin
          if (tick)
          begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == umrc_pkg::TICK_LAST)
            begin
              if (tx_state == umrc_pkg::UMRC_TX_DATA &&
                  tx_bits == frame_bits)
              begin
                txd <= 1'b1;
                // flag at start of stop bit
                tx_stop_pulse <= 1'b1;
                tx_state <= umrc_pkg::UMRC_TX_STOP;
              end
              else
              begin
                txd <= tx_shift[0];
                tx_shift <= {1'b0, tx_shift[8:1]};
                tx_bits <= tx_bits + 4'h1;
                tx_state <= umrc_pkg::UMRC_TX_DATA;
              end
            end
          end
        end
        umrc_pkg::UMRC_TX_STOP:
        begin
          if (tick)
          begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == umrc_pkg::TICK_LAST)
              tx_state <= umrc_pkg::UMRC_TX_IDLE;
          end
        end
        default:
          tx_state <= umrc_pkg::UMRC_TX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Control register
  // field layout
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      serial_mode <= 2'h0;
      multiproc_filter_enable <= 1'b0;
      receive_enable <= 1'b0;
      transmit_ninth_bit <= 1'b0;
    end
    else if (wr_control)
    begin
      // bit 7 is mode only when select is zero
      if (!framing_access_select)
        serial_mode[1] <= reg_wdata[umrc_pkg::BIT_MODE_HIGH];
      serial_mode[0] <= reg_wdata[umrc_pkg::BIT_MODE_LOW];
      multiproc_filter_enable <= reg_wdata[umrc_pkg::BIT_FILTER_ENABLE];
      receive_enable <= reg_wdata[umrc_pkg::BIT_RECEIVE_ENABLE];
      transmit_ninth_bit <= reg_wdata[umrc_pkg::BIT_TX_NINTH];
    end
  end

  // Hardware events win over a same-cycle software write.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      received_ninth_bit <= 1'b0;
      receive_done_flag <= 1'b0;
      transmit_done_flag <= 1'b0;
      rx_data <= umrc_pkg::RESET_BYTE;
    end
    else
    begin
      if (rx_load)
      begin
        received_ninth_bit <= frame_ninth;
        rx_data <= rx_shift[7:0];
        receive_done_flag <= 1'b1;
      end
      else if (wr_control)
      begin
        received_ninth_bit <= reg_wdata[umrc_pkg::BIT_RX_NINTH];
        receive_done_flag <= reg_wdata[umrc_pkg::BIT_RX_DONE];
      end
      if (tx_stop_pulse)
        transmit_done_flag <= 1'b1;
      else if (wr_control)
        transmit_done_flag <= reg_wdata[umrc_pkg::BIT_TX_DONE];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      framing_error_flag <= 1'b0;
    else if (framing_evt)
      framing_error_flag <= 1'b1;
    else if (wr_control && framing_access_select)
      framing_error_flag <= reg_wdata[umrc_pkg::BIT_MODE_HIGH];
  end

  // ==========================================================================
  // Own configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      framing_access_select <= 1'b0;
      double_rate <= 1'b0;
      baud_reload <= umrc_pkg::RESET_BYTE;
      given_address <= umrc_pkg::RESET_BYTE;
      address_mask <= umrc_pkg::RESET_BYTE;
      irq_mask <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        umrc_pkg::REG_AUX_CONTROL:
        begin
          double_rate <= reg_wdata[umrc_pkg::BIT_DOUBLE_RATE];
          framing_access_select <= reg_wdata[umrc_pkg::BIT_FRAMING_SELECT];
        end
        umrc_pkg::REG_BAUD_RELOAD:
          baud_reload <= reg_wdata;
        umrc_pkg::REG_GIVEN_ADDRESS:
          given_address <= reg_wdata;
        umrc_pkg::REG_ADDRESS_MASK:
          address_mask <= reg_wdata;
        umrc_pkg::REG_IRQ_MASK:
          irq_mask <= reg_wdata[EVT_COUNT_W-1:0];
        default:
          ;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt status, write one to clear, set wins
  always_comb
  begin
    evt_vec = '0;
    evt_vec[umrc_pkg::EVT_RX_DONE] = rx_load;
    evt_vec[umrc_pkg::EVT_TX_DONE] = tx_stop_pulse;
    evt_vec[umrc_pkg::EVT_FRAMING] = framing_evt;
    evt_vec[umrc_pkg::EVT_OVERRUN] = rx_overrun;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      irq_status <= '0;
    else if (wr_status)
      irq_status <= (irq_status & ~reg_wdata[EVT_COUNT_W-1:0]) | evt_vec;
    else
      irq_status <= irq_status | evt_vec;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      serial_irq <= 1'b0;
    else
      serial_irq <= |(irq_status & irq_mask);
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      reg_rdata <= umrc_pkg::RESET_BYTE;
    else if (reg_rd)
    begin
      case (reg_addr)
        umrc_pkg::REG_SERIAL_PORT_CONTROL:
          // bit 7 view chosen by select
          reg_rdata <= {framing_access_select ? framing_error_flag
                                              : serial_mode[1],
                        serial_mode[0], multiproc_filter_enable,
                        receive_enable, transmit_ninth_bit,
                        received_ninth_bit, transmit_done_flag,
                        receive_done_flag};
        umrc_pkg::REG_DATA_BUFFER:
          reg_rdata <= rx_data;
        umrc_pkg::REG_AUX_CONTROL:
          reg_rdata <= {double_rate, framing_access_select, 6'h00};
        umrc_pkg::REG_BAUD_RELOAD:
          reg_rdata <= baud_reload;
        umrc_pkg::REG_GIVEN_ADDRESS:
          reg_rdata <= given_address;
        umrc_pkg::REG_ADDRESS_MASK:
          reg_rdata <= address_mask;
        umrc_pkg::REG_IRQ_STATUS:
          reg_rdata <= {4'h0, irq_status};
        umrc_pkg::REG_IRQ_MASK:
          reg_rdata <= {4'h0, irq_mask};
        default:
          reg_rdata <= umrc_pkg::RESET_BYTE;
      endcase
    end
    else
      reg_rdata <= umrc_pkg::RESET_BYTE;
  end

endmodule // umrc_top

`default_nettype wire

// [test/umrc_checker.sv]
/*
  Port-level checker for the serial receive control block.
  Assumes a byte register port and is bound onto umrc_top below.
*/
`timescale 1ns/1ps
`default_nettype none

module umrc_checker
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rxd_pin,
  input wire logic txd,
  input wire logic serial_irq
);
  // ==========================================================
  // Shadows of fields that only software writes
  logic [7:0] ctl_q;
  logic [7:0] mask_q;
  logic sel_q;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ctl_q <= 8'h00;
      mask_q <= 8'h00;
      sel_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        8'h98: ctl_q <= {sel_q ? ctl_q[7] : reg_wdata[7], reg_wdata[6:0]};
        8'hC0: sel_q <= reg_wdata[6];
        8'hC5: mask_q <= {4'h0, reg_wdata[3:0]};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_mask_off;
    mask_q == 8'h00 ##1 mask_q == 8'h00;
  endsequence

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  property p_unmapped;
    reg_rd && reg_addr[7:4] == 4'h0 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ctl_fields;
    s_rd(8'h98) |=> (reg_rdata & 8'h78) == ($past(ctl_q) & 8'h78);
  endproperty
  a_ctl_fields: assert property (p_ctl_fields)
    else $error("control fields read back wrong");
  property p_mode_high;
    s_rd(8'h98) ##0 !sel_q |=> reg_rdata[7] == $past(ctl_q[7]);
  endproperty
  a_mode_high: assert property (p_mode_high)
    else $error("bit 7 not the mode bit");
  property p_aux_sel;
    s_rd(8'hC0) |=> reg_rdata[6] == $past(sel_q);
  endproperty
  a_aux_sel: assert property (p_aux_sel)
    else $error("select bit read back wrong");
  property p_mask_read;
    s_rd(8'hC5) |=> reg_rdata == $past(mask_q);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read back wrong");
  property p_irq_masked;
    s_mask_off |-> !serial_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt high while fully masked");
  property p_irq_rise;
    $rose(serial_irq) |-> $past(mask_q) != 8'h00;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose with mask clear");
endmodule // umrc_checker

bind umrc_top umrc_checker umrc_checker_i
(
  .sys_clk(sys_clk),
  .nrst(nrst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .rxd_pin(rxd_pin),
  .txd(txd),
  .serial_irq(serial_irq)
);

`default_nettype wire

// [test/umrc_line_node.sv]
/*
  Remote node on the serial line: sends frames at a chosen bit length.
  Assumes it is called on a rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module umrc_line_node
(
  input wire logic sys_clk,
  output logic line
);
  initial line = 1'b1;

  // ==========================================================
  // Frame sender
  task automatic send(input logic [8:0] d, input logic stop,
                      input int n, input int bl);
    logic b;
    for (int i = 0; i < n + 2; i++)
    begin
      b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stop;
      line <= b;
      repeat (bl) @(posedge sys_clk);
    end
    // A stale low stop would look like a new start bit.
    line <= 1'b1;
  endtask
endmodule // umrc_line_node

`default_nettype wire

// [test/uart_multiproc_receive_control_test.sv]
/*
  Self-checking bench for the serial receive control block.
  Assumes umrc_top, the line node model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module uart_multiproc_receive_control_test;
  logic sys_clk;
  logic nrst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  wire logic rxd_pin;
  logic txd;
  logic serial_irq;
  logic rd_q;
  logic [15:0] lfsr;
  logic [7:0] expq[$];
  logic [7:0] careq[$];
  int miscompares;
  int compares;

  umrc_top umrc_top_i (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
    .txd(txd), .serial_irq(serial_irq));
  umrc_line_node umrc_line_node_i (.sys_clk(sys_clk), .line(rxd_pin));

  // ==========================================================
  // Clock, helpers and checking
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    expq.push_back(e & m);
    careq.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic irq_is(input logic e);
    @(negedge sys_clk);
    chk("serial_irq", {7'h00, serial_irq}, {7'h00, e});
    @(posedge sys_clk);
  endtask

  task automatic frame(input logic [8:0] d, input logic s, input int n);
    umrc_line_node_i.send(d, s, n, 64);
    repeat (8) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
    rd_q <= reg_rd;

  always @(negedge sys_clk)
  begin
    if (rd_q === 1'b1)
      chk("reg_rdata", reg_rdata & careq.pop_front(),
          expq.pop_front());
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [1:0] mb;
    logic z;
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lfsr = 16'h631C;
    miscompares = 0;
    compares = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(8'h98, 8'h00, 8'hFF);
    rd(8'h07, 8'h00, 8'hFF);
    rd(8'hC5, 8'h00, 8'hFF);
    wr(8'hC1, 8'hFE);
    wr(8'hC5, 8'hFF);
    rd(8'hC5, 8'h0F, 8'hFF);
    for (int m = 0; m < 4; m++)
    begin
      lfsr = lfsr_next(lfsr);
      mb = m[1:0];
      z = (mb != 2'h0);
      wr(8'h98, {mb, 6'h10});
      wr(8'h99, lfsr[15:8]);
      @(negedge sys_clk);
      chk("txd", {7'h00, txd}, {7'h00, !z});
      @(posedge sys_clk);
      umrc_line_node_i.send({lfsr[3], lfsr[7:0]}, 1'b1,
        (mb == 2'h1) ? 8 : 9, (mb == 2'h2) ? 32 : 64);
      repeat (8) @(posedge sys_clk);
      irq_is(z);
      rd(8'h99, z ? lfsr[7:0] : 8'h00, 8'hFF);
      rd(8'h98, {mb, 3'b010, (mb == 2'h1) | (mb[1] & lfsr[3]), z, z},
         8'hFF);
    end
    wr(8'hC5, 8'h00);
    irq_is(1'b0);
    wr(8'hC5, 8'h07);
    irq_is(1'b1);
    rd(8'hC4, 8'h03, 8'hFF);
    wr(8'hC4, 8'hFF);
    irq_is(1'b0);
    wr(8'hC2, 8'h5A);
    wr(8'hC3, 8'hFF);
    wr(8'h98, 8'hF0);
    frame({1'b0, 8'h5A}, 1'b1, 9);
    frame({1'b1, 8'h33}, 1'b1, 9);
    rd(8'h98, 8'hF0, 8'hFB);
    frame({1'b1, 8'h5A}, 1'b1, 9);
    rd(8'h98, 8'hF5, 8'hFF);
    rd(8'h99, 8'h5A, 8'hFF);
    wr(8'h98, 8'hD0);
    frame({1'b0, 8'hA5}, 1'b1, 9);
    rd(8'h98, 8'hD1, 8'hFF);
    wr(8'h98, 8'h70);
    frame({1'b0, lfsr[15:8]}, 1'b0, 8);
    wr(8'hC0, 8'h40);
    rd(8'hC0, 8'h40, 8'h40);
    rd(8'h98, 8'hF0, 8'hFB);
    rd(8'hC4, 8'h05, 8'hFF);
    frame({1'b0, 8'h5A}, 1'b1, 8);
    rd(8'h98, 8'hF1, 8'hFB);
    wr(8'h98, 8'h70);
    rd(8'h98, 8'h70, 8'hFB);
    wr(8'hC0, 8'h00);
    wr(8'h98, 8'hC0);
    frame({1'b1, 8'h96}, 1'b1, 9);
    rd(8'h98, 8'hC0, 8'hFF);
    final_report();
  end
endmodule // uart_multiproc_receive_control_test

`default_nettype wire
